/* File: rtl/adc_seq_pkg.sv */
// constants, types and decode functions for the conversion sequencer
package adc_seq_pkg;

	// --------------------------------------------------------------
	// register word addresses
	// --------------------------------------------------------------
	localparam int             AXI_AW        = 8;
	localparam logic [7:0]     ADDR_FLAGS    = 8'h00;
	localparam logic [7:0]     ADDR_ENABLES  = 8'h04;
	localparam logic [7:0]     ADDR_PRIORITY = 8'h08;
	localparam logic [7:0]     ADDR_RES_HIGH = 8'h0C;
	localparam logic [7:0]     ADDR_RES_LOW  = 8'h10;
	localparam logic [7:0]     ADDR_CTRL_A   = 8'h14;
	localparam logic [7:0]     ADDR_CTRL_B   = 8'h18;
	localparam logic [7:0]     ADDR_CTRL_C   = 8'h1C;
	localparam logic [7:0]     ADDR_PORT_A   = 8'h20;

	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int             DONE_BIT      = 6;
	localparam int             TRIG_BIT      = 7;
	localparam int             GO_BIT        = 1;
	localparam int             PWR_BIT       = 0;
	localparam int             CHAN_LSB      = 2;
	localparam int             REF_BIT       = 4;
	localparam int             FMT_BIT       = 7;
	localparam int             ACQ_LSB       = 3;
	localparam logic [7:0]     CTRL_RESET    = 8'h00;
	localparam logic [7:0]     CTRL_C_MASK   = 8'hBF;
	localparam logic [7:0]     CTRL_B_MASK   = 8'h1F;
	localparam logic [7:0]     CTRL_A_MASK   = 8'h8F;
	localparam logic [7:0]     IRQ_MASK      = 8'h7F;

	// --------------------------------------------------------------
	// sequencing counts
	// --------------------------------------------------------------
	localparam logic [4:0]     CONV_TADS     = 5'h0B;
	localparam logic [4:0]     WAIT_TADS     = 5'h02;
	localparam logic [4:0]     SAR_BITS      = 5'h0A;
	localparam logic [9:0]     SAR_MSB       = 10'h200;
	localparam int             CLK_NS        = 100;
	localparam int             TCY_NS        = 400;
	localparam logic [3:0]     TCY_CYCLES    = 4'((TCY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [1:0]     RESP_OKAY     = 2'h0;
	localparam logic [1:0]     RESP_SLVERR   = 2'h2;

	typedef enum logic [5:0] {
		S_IDLE   = 6'h01,
		S_SAMPLE = 6'h02,
		S_ACQ    = 6'h04,
		S_DELAY  = 6'h08,
		S_CONV   = 6'h10,
		S_WAIT   = 6'h20
	} state_t;

	// acquisition code to bit periods
	function automatic logic [4:0] acq_tads(input logic [2:0] code);
		case (code)
			3'h7:    acq_tads = 5'h14;
			3'h6:    acq_tads = 5'h10;
			3'h5:    acq_tads = 5'h0C;
			3'h4:    acq_tads = 5'h08;
			3'h3:    acq_tads = 5'h06;
			3'h2:    acq_tads = 5'h04;
			3'h1:    acq_tads = 5'h02;
			default: acq_tads = 5'h00;
		endcase
	endfunction : acq_tads

	// clock select code to oscillator periods per bit period
	function automatic logic [6:0] tad_div(input logic [2:0] code);
		case (code)
			3'h0:    tad_div = 7'h02;
			3'h4:    tad_div = 7'h04;
			3'h1:    tad_div = 7'h08;
			3'h5:    tad_div = 7'h10;
			3'h2:    tad_div = 7'h20;
			default: tad_div = 7'h40;
		endcase
	endfunction : tad_div

	function automatic logic is_rc(input logic [2:0] code);
		is_rc = (code[1:0] == 2'h3);
	endfunction : is_rc

endpackage : adc_seq_pkg

/* File: rtl/adc_sequencer.sv */
// acquisition and conversion sequencer with axi4-lite registers
`timescale 1ns/1ps
module adc_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic              clk,         // system clock, 10 MHz
	input  wire logic              sys_rst,     // synchronous reset
	input  wire logic [AXI_AW-1:0] awaddr,      // write address
	input  wire logic              awvalid,     // write address valid
	output logic                   awready,     // write address ready
	input  wire logic [31:0]       wdata,       // write data
	input  wire logic [3:0]        wstrb,       // write strobes
	input  wire logic              wvalid,      // write data valid
	output logic                   wready,      // write data ready
	output logic [1:0]             bresp,       // write response
	output logic                   bvalid,      // write response valid
	input  wire logic              bready,      // write response ready
	input  wire logic [AXI_AW-1:0] araddr,      // read address
	input  wire logic              arvalid,     // read address valid
	output logic                   arready,     // read address ready
	output logic [31:0]            rdata,       // read data
	output logic [1:0]             rresp,       // read response
	output logic                   rvalid,      // read data valid
	input  wire logic              rready,      // read data ready
	input  wire logic              pwm_trigger, // pwm special event pulse
	input  wire logic              rc_osc,      // internal rc conversion clock
	input  wire logic              cmp_in,      // comparator, input above dac
	input  wire logic [7:0]        port_pins,   // port a pin levels
	output logic                   sample_en,   // hold capacitor tracks input
	output logic                   discharge,   // capacitor array discharge
	output logic [1:0]             channel,     // selected analog channel
	output logic                   ref_sel,     // positive reference select
	output logic [9:0]             dac_code     // successive approximation trial
);

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	state_t      state;
	state_t      next_state;
	logic [7:0]  irq_flags_1;
	logic [7:0]  irq_enables_1;
	logic [7:0]  irq_priority_1;
	logic [7:0]  conv_result_high;
	logic [7:0]  conv_result_low;
	logic [7:0]  conv_control_a;
	logic [7:0]  conv_control_b;
	logic [7:0]  conv_control_c;
	logic [4:0]  tad_cnt;
	logic [3:0]  dly_cnt;
	logic [9:0]  sar;
	logic        rc_s1, rc_s2, rc_s3;
	logic        cmp_s1, cmp_s2;
	logic [7:0]  port_s1, port_s2;
	logic        tad_tick;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		rc_s1   <= rc_osc;
		rc_s2   <= rc_s1;
		rc_s3   <= rc_s2;
		cmp_s1  <= cmp_in;
		cmp_s2  <= cmp_s1;
		port_s1 <= port_pins;
		port_s2 <= port_s1;
	end

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire       power_on  = conv_control_a[PWR_BIT];
	wire       go        = conv_control_a[GO_BIT];
	wire [2:0] acq_sel   = conv_control_c[ACQ_LSB +: 3];
	wire [2:0] clk_sel   = conv_control_c[2:0];
	wire [4:0] acq_len   = acq_tads(acq_sel);
	wire       rc_sel    = is_rc(clk_sel);
	wire       rc_tick   = rc_s2 & ~rc_s3;
	wire       last_tad  = tad_tick && (tad_cnt == CONV_TADS - 5'h01);
	wire       complete  = (state == S_CONV) && last_tad && go;
	wire       trig      = pwm_trigger & conv_control_a[TRIG_BIT];
	wire [7:0] analog_mask = {1'b0, ~conv_control_b[3], 1'b0, ~conv_control_b[2],
	                          2'b00, ~conv_control_b[1], ~conv_control_b[0]};
	wire [7:0] port_rd   = port_s2 & ~analog_mask;
	wire [7:0] res_hi_fmt = conv_control_c[FMT_BIT] ? {6'h00, sar[9:8]} : sar[9:2];
	wire [7:0] res_lo_fmt = conv_control_c[FMT_BIT] ? sar[7:0] : {sar[1:0], 6'h00};

	// ----------------------------------------------------------------
	// bit period generator
	// ----------------------------------------------------------------
	tad_gen u_tad (
		.clk     (clk),
		.sys_rst (sys_rst),
		.restart (next_state != state),
		.clk_sel (clk_sel),
		.rc_tick (rc_tick),
		.tick    (tad_tick)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// the same go bit covers acquisition and conversion
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE:
				if (power_on)
					next_state = S_WAIT;
			S_SAMPLE:
				if (go && acq_len != 5'h00)
					next_state = S_ACQ;
				else if (go && rc_sel)
					next_state = S_DELAY;
				else if (go)
					next_state = S_CONV;
			S_ACQ:
				if (!go)
					next_state = S_WAIT;
				else if (tad_tick && tad_cnt == acq_len - 5'h01)
					next_state = S_CONV;
			S_DELAY:
				if (!go)
					next_state = S_WAIT;
				else if (dly_cnt == TCY_CYCLES - 4'h1)
					next_state = S_CONV;
			S_CONV:
				if (!go || last_tad)
					next_state = S_WAIT;
			S_WAIT:
				if (tad_tick && tad_cnt == WAIT_TADS - 5'h01)
					next_state = S_SAMPLE;
			default:
				next_state = S_IDLE;
		endcase
		if (!power_on)
			next_state = S_IDLE;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || next_state != state)
			tad_cnt <= 5'h00;
		else if (tad_tick)
			tad_cnt <= tad_cnt + 5'h01;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || state != S_DELAY)
			dly_cnt <= 4'h0;
		else
			dly_cnt <= dly_cnt + 4'h1;
	end

	// successive approximation, one bit per period from the first, none in the eleventh
	wire [3:0] bit_idx = 4'(SAR_BITS - 5'h01 - tad_cnt);
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sar <= 10'h000;
		else if (state != S_CONV && next_state == S_CONV)
			sar <= SAR_MSB;
		else if (state == S_CONV && tad_tick && tad_cnt < SAR_BITS)
		begin
			sar[bit_idx] <= cmp_s2;
			if (bit_idx != 4'h0)
				sar[bit_idx - 4'h1] <= 1'b1;
		end
	end

	// analog side: channel and pin direction play no part in sequencing
	always_ff @(posedge clk)
	begin
		sample_en <= ~sys_rst & (next_state == S_SAMPLE || next_state == S_ACQ);
		discharge <= ~sys_rst & (next_state == S_WAIT);
		channel   <= sys_rst ? 2'h0 : conv_control_a[CHAN_LSB +: 2];
		ref_sel   <= ~sys_rst & conv_control_b[REF_BIT];
		dac_code  <= sys_rst ? 10'h000 : sar;
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	wire wr_start = awvalid & wvalid & ~awready & ~bvalid;
	wire rd_start = arvalid & ~arready & ~rvalid;
	wire wr_en    = awready & awvalid & wvalid & wstrb[0];
	wire wr_flags = wr_en && awaddr == ADDR_FLAGS;
	wire wr_en_r  = wr_en && awaddr == ADDR_ENABLES;
	wire wr_prio  = wr_en && awaddr == ADDR_PRIORITY;
	wire wr_res_h = wr_en && awaddr == ADDR_RES_HIGH;
	wire wr_res_l = wr_en && awaddr == ADDR_RES_LOW;
	wire wr_ctl_a = wr_en && awaddr == ADDR_CTRL_A;
	wire wr_ctl_b = wr_en && awaddr == ADDR_CTRL_B;
	wire wr_ctl_c = wr_en && awaddr == ADDR_CTRL_C;
	wire aw_hit   = awaddr <= ADDR_CTRL_C && awaddr[1:0] == 2'h0;
	wire ar_hit   = araddr <= ADDR_PORT_A && araddr[1:0] == 2'h0;
	wire [7:0] rd_byte =
		(araddr == ADDR_FLAGS)    ? irq_flags_1 :
		(araddr == ADDR_ENABLES)  ? irq_enables_1 :
		(araddr == ADDR_PRIORITY) ? irq_priority_1 :
		(araddr == ADDR_RES_HIGH) ? conv_result_high :
		(araddr == ADDR_RES_LOW)  ? conv_result_low :
		(araddr == ADDR_CTRL_A)   ? conv_control_a :
		(araddr == ADDR_CTRL_B)   ? conv_control_b :
		(araddr == ADDR_CTRL_C)   ? conv_control_c :
		(araddr == ADDR_PORT_A)   ? port_rd : 8'h00;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end
		else
		begin
			awready <= wr_start;
			wready  <= wr_start;
			if (awready)
			begin
				bvalid <= 1'b1;
				bresp  <= aw_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			arready <= rd_start;
			if (arready)
			begin
				rvalid <= 1'b1;
				rdata  <= {24'h00_0000, rd_byte};
				rresp  <= ar_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			irq_flags_1    <= CTRL_RESET;
			irq_enables_1  <= CTRL_RESET;
			irq_priority_1 <= CTRL_RESET;
			conv_control_b <= CTRL_RESET;
			conv_control_c <= CTRL_RESET;
		end
		else
		begin
			if (wr_flags)
				irq_flags_1 <= wdata[7:0] & IRQ_MASK;
			if (complete)
				irq_flags_1[DONE_BIT] <= 1'b1;
			if (wr_en_r)
				irq_enables_1 <= wdata[7:0] & IRQ_MASK;
			if (wr_prio)
				irq_priority_1 <= wdata[7:0] & IRQ_MASK;
			if (wr_ctl_b)
				conv_control_b <= wdata[7:0] & CTRL_B_MASK;
			if (wr_ctl_c)
				conv_control_c <= wdata[7:0] & CTRL_C_MASK;
		end
	end

	// start flag: hardware clear, then software write, then trigger set
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			conv_control_a <= CTRL_RESET;
		else
		begin
			if (complete || !power_on)
				conv_control_a[GO_BIT] <= 1'b0;
			if (wr_ctl_a)
				conv_control_a <= wdata[7:0] & CTRL_A_MASK;
			if (trig && power_on)
				conv_control_a[GO_BIT] <= 1'b1;
		end
	end

	// result loads on a finished conversion or a bus write, never on abort
	always_ff @(posedge clk)
	begin
		if (complete)
		begin
			conv_result_high <= res_hi_fmt;
			conv_result_low  <= res_lo_fmt;
		end
		else
		begin
			if (wr_res_h)
				conv_result_high <= wdata[7:0];
			if (wr_res_l)
				conv_result_low <= wdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	acq_reset_zero_a: assert property ($past(sys_rst) |-> acq_sel == 3'h0)
		else $error("acquisition field not zero after reset");
	manual_start_a: assert property (
		state == S_SAMPLE && go && acq_sel == 3'h0 && !rc_sel && power_on |=> state == S_CONV)
		else $error("manual start did not convert at once");
	timed_start_a: assert property (
		state == S_SAMPLE && go && acq_sel != 3'h0 && power_on |=> state == S_ACQ && sample_en)
		else $error("programmed acquisition not entered");
	rc_delay_a: assert property (
		state == S_SAMPLE && go && acq_sel == 3'h0 && rc_sel && power_on && !wr_en && !trig
		|=> (state == S_DELAY && go) [*4] ##1 state == S_CONV)
		else $error("rc start delay wrong");
	done_flag_a: assert property (complete && !wr_ctl_a |=> !go && irq_flags_1[DONE_BIT])
		else $error("completion did not clear start or set done");
	conv_len_a: assert property (complete |-> tad_cnt == 5'h0A && state == S_CONV)
		else $error("conversion length not eleven periods");
	abort_keep_a: assert property (
		state == S_CONV && !go && !wr_res_h |=> $stable(conv_result_high) && state != S_CONV)
		else $error("abort changed result");
	discharge_a: assert property ($rose(state == S_SAMPLE) |-> $past(discharge))
		else $error("sampling without discharge");
	port_mask_a: assert property (!conv_control_b[0] |-> port_rd[0] == 1'b0)
		else $error("analog pin reads nonzero");
	power_off_a: assert property (!power_on |=> state == S_IDLE && !go)
		else $error("converter active while off");

	complete_c: cover property (complete);
	abort_c:    cover property (state == S_CONV && !go);
	trigger_c:  cover property (trig && state == S_SAMPLE);
	rc_wait_c:  cover property (state == S_DELAY ##1 state == S_CONV);

endmodule : adc_sequencer

/* File: rtl/tad_gen.sv */
// bit period tick generator from oscillator divider or rc clock
`timescale 1ns/1ps
module tad_gen
	import adc_seq_pkg::*;
(
	input  wire logic       clk,      // system clock
	input  wire logic       sys_rst,  // synchronous reset
	input  wire logic       restart,  // zero the divider
	input  wire logic [2:0] clk_sel,  // conversion clock select
	input  wire logic       rc_tick,  // synchronised rc edge
	output logic            tick      // one pulse per bit period
);

	logic [6:0] div_cnt;
	wire  [6:0] div_last = tad_div(clk_sel) - 7'h01;
	wire        use_rc   = is_rc(clk_sel);

	always_ff @(posedge clk)
	begin
		if (sys_rst || restart)
		begin
			div_cnt <= 7'h00;
			tick    <= 1'b0;
		end
		else if (use_rc)
		begin
			div_cnt <= 7'h00;
			tick    <= rc_tick;
		end
		else if (div_cnt >= div_last)
		begin
			div_cnt <= 7'h00;
			tick    <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt + 7'h01;
			tick    <= 1'b0;
		end
	end

endmodule : tad_gen

/* File: testbench/analog_src_model.sv */
// sample-and-hold and comparator model of the selected analog input
`timescale 1ns/1ps
module analog_src_model
(
	input  wire logic        clk,       // system clock
	input  wire logic        sample_en, // hold capacitor tracks input
	input  wire logic        discharge, // capacitor array discharge
	input  wire logic [1:0]  channel,   // selected channel
	input  wire logic [9:0]  dac_code,  // trial code
	input  wire logic [39:0] levels,    // four 10-bit channel levels
	output logic             cmp_in     // input above trial code
);
	logic [9:0] held;

	always_ff @(posedge clk)
		if (discharge)
			held <= 10'h000;
		else if (sample_en)
			held <= levels[channel*10 +: 10];

	// half-code offset so strict and loose compares agree
	assign cmp_in = {held, 1'b1} > {dac_code, 1'b0};
endmodule : analog_src_model

/* File: testbench/tb_top.sv */
// self-checking bench for the acquisition and conversion sequencer
`timescale 1ns/1ps
module tb_top
	import adc_seq_pkg::*;
;
	localparam logic [39:0] LV       = {10'h001, 10'h3FF, 10'h15A, 10'h2A5};
	localparam int          ACQ_T[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	localparam int          DIVS[8]  = '{2, 8, 32, 12, 4, 16, 64, 12};
	localparam logic [2:0]  CSEQ[8]  = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
	logic              clk = 1'b0, sys_rst = 1'b1;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic [31:0]       wdata = '0, rdata, rv;
	logic [3:0]        wstrb = 4'hF;
	logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic              pwm_trigger = 0, rc_osc = 0, cmp_in;
	logic [7:0]        port_pins = 8'hFF;
	logic              awready, wready, bvalid, arready, rvalid, sample_en, discharge, ref_sel;
	logic [1:0]        bresp, rresp, channel, rsp;
	logic [9:0]        dac_code;
	int                mismatches = 0, n_checks = 0, cycles = 0, rc_cnt = 0;

	adc_sequencer uut (.clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.pwm_trigger, .rc_osc, .cmp_in, .port_pins, .sample_en, .discharge, .channel, .ref_sel, .dac_code);
	analog_src_model pm (.clk, .sample_en, .discharge, .channel, .dac_code, .levels(LV), .cmp_in);

	always #50 clk = ~clk;

	// free-running rc clock, 12 system clocks per period; run ceiling
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		rc_cnt <= (rc_cnt == 5) ? 0 : rc_cnt + 1;
		if (rc_cnt == 5)
			rc_osc <= ~rc_osc;
		if (cycles == 30000)
		begin
			mismatches++;
			conclude();
		end
	end

	// --------------------------------------------------------------
	// bus and checking helpers
	// --------------------------------------------------------------
	task automatic conclude();
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic win(input int n, input int lo, input int hi);
		chk(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
	endtask : win

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		rsp = bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		rv = rdata;
		rsp = rresp;
	endtask : rd

	task automatic span(input logic dis, input logic lvl, output int n);
		n = 0;
		while ((dis ? discharge : sample_en) !== lvl)
		begin
			@(posedge clk);
			n++;
		end
	endtask : span

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic scn_port();
		wr(ADDR_CTRL_B, 32'h1F);
		rd(ADDR_PORT_A);
		chk(rv, 32'hFF);
		chk(32'(ref_sel), 32'h1);
		wr(ADDR_CTRL_B, 32'h00);
		rd(ADDR_PORT_A);
		chk(rv, 32'hAC);
		chk(32'(ref_sel), 32'h0);
		wr(ADDR_PORT_A, 32'h00);
		chk(32'(rsp), 32'(RESP_SLVERR));
		rd(8'h40);
		chk(32'(rsp), 32'(RESP_SLVERR));
	endtask : scn_port

	task automatic conv(input logic [2:0] acq, input logic [2:0] cs, input logic [1:0] ch, input logic fmt);
		int d, e, tl, sl, n;
		logic [9:0] v;
		d = DIVS[cs];
		e = ACQ_T[acq] * d;
		tl = (cs[1:0] == 2'h3) ? 14 : 3;
		// free-running rc clock: first period may be cut short
		sl = (tl > 3) ? 12 : 2;
		v = LV[ch*10 +: 10];
		span(1'b0, 1'b1, n);
		wr(ADDR_FLAGS, 32'h0);
		wr(ADDR_CTRL_C, {24'h0, fmt, 1'b0, acq, cs});
		// channel first, so manual acquisition tracks it before start
		wr(ADDR_CTRL_A, {28'h0, ch, 2'h1});
		wr(ADDR_CTRL_A, {28'h0, ch, 2'h3});
		span(1'b0, 1'b0, n);
		win(n, e - sl, e + tl);
		e = 11 * d + ((tl > 3 && acq == 3'h0) ? 4 : 0);
		span(1'b1, 1'b1, n);
		win(n, e - sl, e + tl);
		span(1'b0, 1'b1, n);
		win(n, 2 * d - sl, 2 * d + tl);
		chk(32'(channel), 32'(ch));
		rd(ADDR_CTRL_A);
		chk(rv, {28'h0, ch, 2'h1});
		rd(ADDR_FLAGS);
		chk(rv, 32'h40);
		rd(ADDR_RES_HIGH);
		chk(rv, fmt ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
		rd(ADDR_RES_LOW);
		chk(rv, fmt ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
	endtask : conv

	task automatic scn_abort();
		wr(ADDR_RES_HIGH, 32'h5A);
		wr(ADDR_RES_LOW, 32'hC3);
		wr(ADDR_FLAGS, 32'h0);
		wr(ADDR_CTRL_C, 32'h06);
		wr(ADDR_CTRL_A, 32'h03);
		repeat (200) @(posedge clk);
		wr(ADDR_CTRL_A, 32'h01);
		repeat (8) @(posedge clk);
		chk(32'(discharge), 32'h1);
		rd(ADDR_RES_HIGH);
		chk(rv, 32'h5A);
		rd(ADDR_RES_LOW);
		chk(rv, 32'hC3);
		rd(ADDR_FLAGS);
		chk(rv, 32'h00);
	endtask : scn_abort

	task automatic scn_pwm();
		int n;
		wr(ADDR_CTRL_C, 32'h81);
		span(1'b0, 1'b1, n);
		wr(ADDR_CTRL_A, 32'h81);
		pwm_trigger <= 1'b1;
		@(posedge clk);
		pwm_trigger <= 1'b0;
		repeat (140) @(posedge clk);
		rd(ADDR_FLAGS);
		chk(rv, 32'h40);
		rd(ADDR_CTRL_A);
		chk(rv, 32'h81);
		rd(ADDR_RES_LOW);
		chk(rv, 32'hA5);
	endtask : scn_pwm

	initial
	begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rd(ADDR_CTRL_C);
		chk(rv, 32'h0);
		rd(ADDR_CTRL_A);
		chk(rv, 32'h0);
		scn_port();
		wr(ADDR_CTRL_A, 32'h01);
		// two-period clock outruns the comparator path; full-scale input keeps it exact
		for (int i = 0; i < 8; i++)
			conv(3'(i), CSEQ[i], 2'(i + 2), 1'b1);
		conv(3'h2, 3'h1, 2'h0, 1'b0);
		conv(3'h0, 3'h3, 2'h2, 1'b0);
		scn_abort();
		scn_pwm();
		conclude();
	end
endmodule : tb_top
